/* src/fcs_pkg.sv */
// Shared constants and types for the filter configuration serial port
package fcs_pkg;

	// Command bytes: low bit set means read
	localparam logic [7:0] FCS_OP_REG_WR = 8'h82;
	localparam logic [7:0] FCS_OP_REG_RD = 8'h83;
	localparam logic [7:0] FCS_OP_COEF_WR = 8'h86;
	localparam logic [7:0] FCS_OP_COEF_RD = 8'h87;
	localparam int FCS_OP_READ_BIT = 0;

	// Register offsets in the configuration space
	localparam logic [7:0] FCS_ADDR_CTRL = 8'h03;
	localparam logic [7:0] FCS_ADDR_SETUP = 8'h04;

	// Field positions
	localparam int FCS_CTRL_FILT_BIT = 0;
	localparam int FCS_CTRL_PT_BIT = 1;
	localparam int FCS_SETUP_SCLK_POL_BIT = 0;

	// Values after reset
	localparam logic [7:0] FCS_CTRL_RESET = 8'h00;
	localparam logic [7:0] FCS_SETUP_RESET = 8'h00;
	localparam logic [7:0] FCS_RDATA_RESET = 8'h00;

	// Frame layout in serial clocks
	localparam int FCS_BYTE_BITS = 8;
	localparam int FCS_DUMMY_CLKS = 6;
	localparam int FCS_DEAD_CLKS = 2;
	localparam logic [2:0] FCS_CNT_BYTE_LAST = 3'(FCS_BYTE_BITS - 1);
	localparam logic [2:0] FCS_CNT_DUMMY_LAST = 3'(FCS_DUMMY_CLKS - 1);
	localparam logic [2:0] FCS_CNT_DEAD_LAST = 3'(FCS_DEAD_CLKS - 1);

	// Coefficient byte address is the word index times four
	localparam int FCS_COEF_BYTE_SHIFT = 2;

	// Cycles from coefficient read address to captured data
	localparam int FCS_COEF_RD_LAT = 2;

	// Phases of one configuration frame
	typedef enum logic [2:0]
	{
		FCS_OPCODE,
		FCS_DUMMY,
		FCS_ADDRESS,
		FCS_DEAD,
		FCS_DATA,
		FCS_IGNORE
	} fcs_phase_e;

	// Append one serial bit to seven already held, MSB first
	function automatic logic [7:0] fcs_shift_in(input logic [6:0] held, input logic bit_in);
		fcs_shift_in = {held, bit_in};
	endfunction

endpackage

/* src/fcs_spi.sv */
// Configuration serial slave port of the FIR filter device
`timescale 1ns/100ps
`default_nettype none
module fcs_spi
	import fcs_pkg::*;
#(
	parameter int PTR_W = 10
)
(
	// System clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Chip reset pin
	input wire logic chip_reset_n,
	// Configuration serial pins
	input wire logic cfg_serial_clock,
	input wire logic cfg_select_n,
	input wire logic cfg_serial_in,
	output logic cfg_serial_out,
	output logic cfg_serial_out_en,
	// Stream pins and filtered stream from the data path
	input wire logic stream_serial_in,
	input wire logic stream_filtered_out,
	output logic stream_serial_out,
	output logic stream_serial_out_en,
	// Mode and setup towards the data path
	output logic filter_enable_bit,
	output logic data_passthrough_bit,
	output logic [7:0] serial_interface_setup,
	// Other configuration registers, held in the data path
	output logic reg_wr_en,
	output logic [7:0] reg_wr_addr,
	output logic [7:0] reg_wr_data,
	// Coefficient memory ports
	output logic coef_wr_en,
	output logic [PTR_W-1:0] coef_wr_addr,
	output logic [7:0] coef_wr_data,
	output logic [PTR_W-1:0] coef_rd_addr,
	input wire logic [7:0] coef_rd_data
);

	// Per-frame state on the serial clock, cleared whenever select is high
	typedef struct packed
	{
		fcs_phase_e phase;
		logic [2:0] cnt;
		logic [6:0] shift;
		logic is_read;
		logic is_coef;
		logic [PTR_W-1:0] ptr;
		logic [7:0] tx;
		logic drive;
	} fcs_frame_s;

	// Crossing holders on the serial clock; they survive frame ends
	typedef struct packed
	{
		logic wr_tgl;
		logic wr_coef;
		logic [PTR_W-1:0] wr_ptr;
		logic [7:0] wr_byte;
		logic rd_tgl;
		logic rd_coef;
		logic [PTR_W-1:0] rd_ptr;
	} fcs_xfer_s;

	// System clock state
	typedef struct packed
	{
		logic rst_m;
		logic rst_s;
		logic cs_m;
		logic cs_s;
		logic wr_m;
		logic wr_s;
		logic wr_q;
		logic rd_m;
		logic rd_s;
		logic rd_q;
		logic [7:0] ctrl;
		logic [7:0] setup;
		logic pol;
		logic [7:0] rd_data;
		logic [FCS_COEF_RD_LAT-1:0] coef_pend;
		logic coef_we;
		logic [PTR_W-1:0] coef_addr;
		logic [7:0] coef_data;
		logic [PTR_W-1:0] coef_raddr;
		logic reg_we;
		logic [7:0] reg_addr;
		logic [7:0] reg_data;
	} fcs_core_s;

	fcs_frame_s frm;
	fcs_frame_s next_frm;
	fcs_xfer_s xfr;
	fcs_xfer_s next_xfr;
	fcs_core_s core;
	fcs_core_s next_core;
	logic launch_bit;
	logic chip_rst;
	logic cfg_mode;
	logic sck_eff;
	logic frame_rst;
	logic xfer_rst;
	logic [7:0] in_byte;

	// Reset pin counts as asserted until two flops see it released
	assign chip_rst = ~core.rst_s;
	// Configure mode: neither filter nor passthrough set
	assign cfg_mode = ~core.ctrl[FCS_CTRL_FILT_BIT] & ~core.ctrl[FCS_CTRL_PT_BIT];
	// Polarity only changes while deselected, so the inverted clock never glitches mid-frame
	assign sck_eff = cfg_serial_clock ^ core.pol;
	// Select high clears the frame decoder at once
	assign frame_rst = sys_rst | chip_rst | cfg_select_n;
	assign xfer_rst = sys_rst | chip_rst;
	assign in_byte = fcs_shift_in(frm.shift, cfg_serial_in);

	// Frame decoder on the effective serial clock
	always_comb
	begin
		next_frm = frm;
		next_xfr = xfr;
		next_frm.shift = in_byte[6:0];
		next_frm.cnt = frm.cnt + 3'h1;
		unique case (frm.phase)
			FCS_OPCODE:
			begin
				if (frm.cnt == FCS_CNT_BYTE_LAST)
				begin
					next_frm.cnt = 3'h0;
					next_frm.is_read = in_byte[FCS_OP_READ_BIT];
					next_frm.is_coef = (in_byte == FCS_OP_COEF_WR) || (in_byte == FCS_OP_COEF_RD);
					if ((in_byte == FCS_OP_REG_WR) || (in_byte == FCS_OP_REG_RD) || next_frm.is_coef)
						next_frm.phase = FCS_DUMMY;
					else
						next_frm.phase = FCS_IGNORE;
				end
			end
			FCS_DUMMY:
			begin
				// Input value during these clocks has no effect
				if (frm.cnt == FCS_CNT_DUMMY_LAST)
				begin
					next_frm.cnt = 3'h0;
					next_frm.phase = FCS_ADDRESS;
				end
			end
			FCS_ADDRESS:
			begin
				if (frm.cnt == FCS_CNT_BYTE_LAST)
				begin
					next_frm.cnt = 3'h0;
					next_frm.ptr = frm.is_coef ?
						PTR_W'({in_byte, 2'b00}) : PTR_W'(in_byte);
					if (frm.is_read)
					begin
						// Fetch the first byte during the dead clocks
						next_xfr.rd_tgl = ~xfr.rd_tgl;
						next_xfr.rd_coef = frm.is_coef;
						next_xfr.rd_ptr = next_frm.ptr;
						next_frm.ptr = next_frm.ptr + PTR_W'(1);
						next_frm.phase = FCS_DEAD;
					end
					else
						next_frm.phase = FCS_DATA;
				end
			end
			FCS_DEAD:
			begin
				if (frm.cnt == FCS_CNT_DEAD_LAST)
				begin
					next_frm.cnt = 3'h0;
					next_frm.tx = core.rd_data;
					next_frm.drive = 1'b1;
					next_xfr.rd_tgl = ~xfr.rd_tgl;
					next_xfr.rd_ptr = frm.ptr;
					next_frm.ptr = frm.ptr + PTR_W'(1);
					next_frm.phase = FCS_DATA;
				end
			end
			FCS_DATA:
			begin
				if (frm.is_read)
				begin
					next_frm.tx = {frm.tx[6:0], 1'b0};
					if (frm.cnt == FCS_CNT_BYTE_LAST)
					begin
						// Next location was fetched a byte ago
						next_frm.tx = core.rd_data;
						next_xfr.rd_tgl = ~xfr.rd_tgl;
						next_xfr.rd_ptr = frm.ptr;
						next_frm.ptr = frm.ptr + PTR_W'(1);
					end
				end
				else if (frm.cnt == FCS_CNT_BYTE_LAST)
				begin
					next_xfr.wr_tgl = ~xfr.wr_tgl;
					next_xfr.wr_coef = frm.is_coef;
					next_xfr.wr_ptr = frm.ptr;
					next_xfr.wr_byte = in_byte;
					next_frm.ptr = frm.ptr + PTR_W'(1);
				end
			end
			FCS_IGNORE:
			begin
				next_frm.cnt = frm.cnt;
			end
		endcase
	end

	// Frame registers, capture edge
	always_ff @(posedge sck_eff or posedge frame_rst)
	begin
		if (frame_rst)
			frm <= '{phase: FCS_OPCODE, cnt: 3'h0, shift: 7'h00, is_read: 1'b0,
				is_coef: 1'b0, ptr: '0, tx: 8'h00, drive: 1'b0};
		else
			frm <= next_frm;
	end

	// Crossing holders, capture edge
	always_ff @(posedge sck_eff or posedge xfer_rst)
	begin
		if (xfer_rst)
			xfr <= '0;
		else
			xfr <= next_xfr;
	end

	// Output launched on the edge opposite to capture
	always_ff @(negedge sck_eff or posedge frame_rst)
	begin
		if (frame_rst)
			launch_bit <= 1'b0;
		else
			launch_bit <= frm.tx[7];
	end

	// Slave only: the pin driver is the data line, never clock or select
	assign cfg_serial_out = launch_bit;
	assign cfg_serial_out_en = ~cfg_select_n & frm.drive & cfg_mode;

	// System clock side: synchronisers, registers, memory strobes
	always_comb
	begin
		next_core = core;
		next_core.rst_m = chip_reset_n;
		next_core.rst_s = core.rst_m;
		next_core.cs_m = cfg_select_n;
		next_core.cs_s = core.cs_m;
		next_core.wr_m = xfr.wr_tgl;
		next_core.wr_s = core.wr_m;
		next_core.wr_q = core.wr_s;
		next_core.rd_m = xfr.rd_tgl;
		next_core.rd_s = core.rd_m;
		next_core.rd_q = core.rd_s;
		next_core.coef_we = 1'b0;
		next_core.reg_we = 1'b0;
		next_core.coef_pend = {core.coef_pend[FCS_COEF_RD_LAT-2:0], 1'b0};
		// Take the new polarity only between frames
		if (core.cs_s)
			next_core.pol = core.setup[FCS_SETUP_SCLK_POL_BIT];
		// Write event: holders are stable for a whole byte time
		if (core.wr_s != core.wr_q)
		begin
			if (xfr.wr_coef)
			begin
				if (cfg_mode)
				begin
					next_core.coef_we = 1'b1;
					next_core.coef_addr = xfr.wr_ptr;
					next_core.coef_data = xfr.wr_byte;
				end
			end
			else if (xfr.wr_ptr[7:0] == FCS_ADDR_CTRL)
				next_core.ctrl = xfr.wr_byte;
			else if (xfr.wr_ptr[7:0] == FCS_ADDR_SETUP)
				next_core.setup = xfr.wr_byte;
			else
			begin
				next_core.reg_we = 1'b1;
				next_core.reg_addr = xfr.wr_ptr[7:0];
				next_core.reg_data = xfr.wr_byte;
			end
		end
		// Read event: registers answer at once, memory after its latency
		if (core.rd_s != core.rd_q)
		begin
			if (xfr.rd_coef)
			begin
				next_core.coef_raddr = xfr.rd_ptr;
				next_core.coef_pend[0] = 1'b1;
			end
			else if (xfr.rd_ptr[7:0] == FCS_ADDR_CTRL)
				next_core.rd_data = core.ctrl;
			else if (xfr.rd_ptr[7:0] == FCS_ADDR_SETUP)
				next_core.rd_data = core.setup;
			else
				next_core.rd_data = FCS_RDATA_RESET;
		end
		// Coefficients read back only in configure mode
		if (core.coef_pend[FCS_COEF_RD_LAT-1])
			next_core.rd_data = cfg_mode ? coef_rd_data : FCS_RDATA_RESET;
		// Chip reset pin clears state, keeping toggle pairs in step with the link side
		if (chip_rst)
		begin
			next_core.wr_m = 1'b0;
			next_core.wr_s = 1'b0;
			next_core.wr_q = 1'b0;
			next_core.rd_m = 1'b0;
			next_core.rd_s = 1'b0;
			next_core.rd_q = 1'b0;
			next_core.ctrl = FCS_CTRL_RESET;
			next_core.setup = FCS_SETUP_RESET;
			next_core.pol = FCS_SETUP_RESET[FCS_SETUP_SCLK_POL_BIT];
			next_core.rd_data = FCS_RDATA_RESET;
			next_core.coef_pend = '0;
			next_core.coef_we = 1'b0;
			next_core.reg_we = 1'b0;
		end
	end

	// System clock registers
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			core <= '{rst_m: 1'b0, rst_s: 1'b0, cs_m: 1'b1, cs_s: 1'b1,
				ctrl: FCS_CTRL_RESET, setup: FCS_SETUP_RESET,
				pol: FCS_SETUP_RESET[FCS_SETUP_SCLK_POL_BIT],
				rd_data: FCS_RDATA_RESET, default: '0};
		else
			core <= next_core;
	end

	// Mode, setup, register write and coefficient memory outputs
	assign filter_enable_bit = core.ctrl[FCS_CTRL_FILT_BIT];
	assign data_passthrough_bit = core.ctrl[FCS_CTRL_PT_BIT];
	assign serial_interface_setup = core.setup;
	assign reg_wr_en = core.reg_we;
	assign reg_wr_addr = core.reg_addr;
	assign reg_wr_data = core.reg_data;
	assign coef_wr_en = core.coef_we;
	assign coef_wr_addr = core.coef_addr;
	assign coef_wr_data = core.coef_data;
	assign coef_rd_addr = core.coef_raddr;

	// Stream output: passthrough is a plain wire path and beats everything else
	assign stream_serial_out = data_passthrough_bit ? stream_serial_in : stream_filtered_out;
	assign stream_serial_out_en = data_passthrough_bit | filter_enable_bit;

endmodule
`default_nettype wire

/* test/fcs_spi_asserts.sv */
// Pin-level checks of the configuration serial port
`timescale 1ns/100ps
`default_nettype none
module fcs_spi_asserts
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Serial and stream pins
	input wire logic cfg_select_n,
	input wire logic cfg_serial_out_en,
	input wire logic stream_serial_in,
	input wire logic stream_filtered_out,
	input wire logic stream_serial_out,
	input wire logic stream_serial_out_en,
	// Mode bits and strobes
	input wire logic filter_enable_bit,
	input wire logic data_passthrough_bit,
	input wire logic reg_wr_en,
	input wire logic coef_wr_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Output stays driven while the port is still selected
	sequence s_en_kept;
		cfg_serial_out_en ##1 !cfg_select_n;
	endsequence
	property p_out_mode;
		cfg_serial_out_en |-> !filter_enable_bit && !data_passthrough_bit;
	endproperty
	a_out_mode: assert property (p_out_mode) else $error("out driven in data mode");
	property p_out_desel;
		cfg_select_n |-> !cfg_serial_out_en;
	endproperty
	a_out_desel: assert property (p_out_desel) else $error("out driven deselected");
	// A read needs 24 serial clocks, far more than 8 system clocks
	property p_out_late;
		$fell(cfg_select_n) |-> !cfg_serial_out_en [*8];
	endproperty
	a_out_late: assert property (p_out_late) else $error("out driven too early");
	property p_out_hold;
		s_en_kept |-> cfg_serial_out_en;
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("out dropped mid read");
	property p_pt;
		data_passthrough_bit |-> stream_serial_out == stream_serial_in;
	endproperty
	a_pt: assert property (p_pt) else $error("passthrough broken");
	property p_filt;
		!data_passthrough_bit |-> stream_serial_out == stream_filtered_out;
	endproperty
	a_filt: assert property (p_filt) else $error("filtered stream lost");
	property p_str_en;
		stream_serial_out_en == (filter_enable_bit || data_passthrough_bit);
	endproperty
	a_str_en: assert property (p_str_en) else $error("stream enable wrong");
	property p_coef_mode;
		coef_wr_en |-> !filter_enable_bit;
	endproperty
	a_coef_mode: assert property (p_coef_mode) else $error("coef write in data mode");
	// Bytes are 8 serial clocks apart, so strobes never touch
	property p_coef_pulse;
		coef_wr_en |=> !coef_wr_en [*8];
	endproperty
	a_coef_pulse: assert property (p_coef_pulse) else $error("coef strobe too long");
	property p_reg_pulse;
		reg_wr_en |=> !reg_wr_en [*8];
	endproperty
	a_reg_pulse: assert property (p_reg_pulse) else $error("reg strobe too long");
endmodule
bind fcs_spi fcs_spi_asserts u_chk (.clk, .sys_rst, .cfg_select_n, .cfg_serial_out_en,
	.stream_serial_in, .stream_filtered_out, .stream_serial_out, .stream_serial_out_en,
	.filter_enable_bit, .data_passthrough_bit, .reg_wr_en, .coef_wr_en);
`default_nettype wire

/* test/fcs_master.sv */
// Serial master model driving the configuration port
`timescale 1ns/100ps
`default_nettype none
module fcs_master
(
	// Serial pins
	output logic sclk,
	output logic sel_n,
	output logic mosi,
	input wire logic miso
);
	logic pol = 1'b0;
	logic [7:0] wq[$];
	logic [7:0] rq[$];
	// Idle: deselected, clock still
	initial
	begin
		sclk = 1'b0;
		sel_n = 1'b1;
		mosi = 1'b0;
	end
	// One bit: capture edge, then launch edge, 15 ns period
	task automatic bit1(input logic o, output logic i);
		mosi = o;
		// Faster than the pin limit, which only tightens the crossing margins
		#7.5 sclk = ~sclk;
		i = miso;
		#7.5 sclk = ~sclk;
	endtask
	task automatic byte8(input logic [7:0] o, output logic [7:0] i);
		for (int k = 7; k >= 0; k--) bit1(o[k], i[k]);
	endtask
	// Whole frame; reads return bytes into rq, writes take them from wq
	task automatic frame(input logic [7:0] op, input logic [7:0] adr, input int n);
		logic [7:0] b;
		sclk = pol;
		#20 sel_n = 1'b0;
		#24 byte8(op, b);
		repeat (6) bit1(1'b1, b[0]);
		byte8(adr, b);
		if (op[0])
			repeat (2) bit1(1'b1, b[0]);
		repeat (n)
		begin
			byte8(op[0] ? 8'h00 : wq.pop_front(), b);
			if (op[0])
				rq.push_back(b);
		end
		#24 sel_n = 1'b1;
		mosi = ~mosi;
		#50;
	endtask
	// Frame cut short k bits after a full opcode byte
	task automatic cut(input logic [7:0] op, input int k);
		logic [7:0] b;
		sclk = pol;
		#20 sel_n = 1'b0;
		#24 byte8(op, b);
		repeat (k) bit1(1'b1, b[0]);
		#24 sel_n = 1'b1;
		#50;
	endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the configuration serial port
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
	$display("unexpected %0t got %h exp %h", $time, (a), (e)); end end
module tb
	import fcs_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic chip_reset_n = 1'b1;
	logic s_in = 1'b0;
	logic f_out = 1'b0;
	logic [7:0] rd_data = 8'h00;
	logic sclk, sel_n, mosi, so, so_en, s_out, s_en, filt, pt, rwe, cwe;
	logic [7:0] setup, raddr, rdata, cdata;
	logic [9:0] caddr, rd_addr;
	logic [7:0] mem [1024];
	logic [15:0] rlog[$];
	logic [17:0] clog[$];
	int fails = 0;
	int samples_checked = 0;
	tri miso;
	assign miso = so_en ? so : 1'bz;
	// 250 MHz system clock
	always #2 clk = ~clk;
	fcs_spi #(.PTR_W(10)) DUT (.clk(clk), .sys_rst(sys_rst), .chip_reset_n(chip_reset_n),
		.cfg_serial_clock(sclk), .cfg_select_n(sel_n), .cfg_serial_in(mosi),
		.cfg_serial_out(so), .cfg_serial_out_en(so_en), .stream_serial_in(s_in),
		.stream_filtered_out(f_out), .stream_serial_out(s_out), .stream_serial_out_en(s_en),
		.filter_enable_bit(filt), .data_passthrough_bit(pt), .serial_interface_setup(setup),
		.reg_wr_en(rwe), .reg_wr_addr(raddr), .reg_wr_data(rdata), .coef_wr_en(cwe),
		.coef_wr_addr(caddr), .coef_wr_data(cdata), .coef_rd_addr(rd_addr),
		.coef_rd_data(rd_data));
	fcs_master m (.sclk(sclk), .sel_n(sel_n), .mosi(mosi), .miso(miso));
	// Blank RAM so unwritten reads are defined
	initial foreach (mem[i]) mem[i] = 8'h00;
	// Sync coefficient RAM and strobe logs
	always @(posedge clk)
	begin
		if (cwe) mem[caddr] <= cdata;
		rd_data <= mem[rd_addr];
		if (rwe) rlog.push_back({raddr, rdata});
		if (cwe) clog.push_back({caddr, cdata});
	end
	task automatic wr(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] d);
		m.wq.push_back(d);
		m.frame(op, adr, 1);
	endtask
	task automatic rd(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] e);
		m.rq.delete();
		m.frame(op, adr, 1);
		`CHK(m.rq[0], e)
	endtask
	task automatic t_reset();
		`CHK({filt, pt}, 2'b00)
		`CHK(setup, FCS_SETUP_RESET)
		rd(FCS_OP_REG_RD, FCS_ADDR_CTRL, FCS_CTRL_RESET);
	endtask
	// Burst over setup and two outside registers, then falling-edge capture
	task automatic t_regs();
		m.wq = '{8'h01, 8'ha5, 8'h3c};
		m.frame(FCS_OP_REG_WR, FCS_ADDR_SETUP, 3);
		`CHK(setup, 8'h01)
		`CHK(rlog.pop_front(), {8'h05, 8'ha5})
		`CHK(rlog.pop_front(), {8'h06, 8'h3c})
		m.pol = 1'b1;
		m.rq.delete();
		m.frame(FCS_OP_REG_RD, FCS_ADDR_CTRL, 2);
		`CHK(m.rq[0], 8'h00)
		`CHK(m.rq[1], 8'h01)
		wr(FCS_OP_REG_WR, FCS_ADDR_SETUP, 8'h00);
		m.pol = 1'b0;
		rd(FCS_OP_REG_RD, FCS_ADDR_SETUP, 8'h00);
	endtask
	task automatic t_coef();
		logic [7:0] c [5] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a};
		m.wq = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a};
		m.frame(FCS_OP_COEF_WR, 8'h02, 5);
		for (int k = 0; k < 5; k++) `CHK(clog[k], {10'(8 + k), c[k]})
		m.rq.delete();
		m.frame(FCS_OP_COEF_RD, 8'h02, 4);
		for (int k = 0; k < 4; k++) `CHK(m.rq[k], c[k])
		clog.delete();
		rd(FCS_OP_REG_RD, 8'h07, 8'h00);
	endtask
	// Data mode drops coefficients, passthrough overrides, then back
	task automatic t_mode();
		wr(FCS_OP_REG_WR, FCS_ADDR_CTRL, 8'h01);
		`CHK({filt, pt, s_en}, 3'b101)
		@(negedge clk);
		f_out = ~f_out;
		#1 `CHK(s_out, f_out)
		// Data mode keeps the output pin released during a read
		rd(FCS_OP_REG_RD, FCS_ADDR_CTRL, 8'hzz);
		wr(FCS_OP_COEF_WR, 8'h00, 8'hee);
		`CHK(clog.size(), 0)
		wr(FCS_OP_REG_WR, FCS_ADDR_CTRL, 8'h03);
		@(negedge clk);
		// Stream input has its own line, so no sample can alias an opcode
		s_in = ~s_in;
		#1 `CHK(s_out, s_in)
		wr(FCS_OP_REG_WR, FCS_ADDR_CTRL, 8'h00);
		`CHK({filt, pt, s_en}, 3'b000)
	endtask
	// Cut frame and unknown command leave no trace
	task automatic t_abort();
		// Write cut inside its first data byte must not land
		m.cut(FCS_OP_REG_WR, 18);
		// Near-miss opcode must not write the setup register
		wr(8'h84, FCS_ADDR_SETUP, 8'h5a);
		rd(FCS_OP_REG_RD, FCS_ADDR_SETUP, 8'h00);
		`CHK(rlog.size(), 0)
	endtask
	task automatic t_chip();
		wr(FCS_OP_REG_WR, FCS_ADDR_SETUP, 8'h80);
		`CHK(setup, 8'h80)
		wr(FCS_OP_REG_WR, FCS_ADDR_CTRL, 8'h02);
		`CHK({filt, pt}, 2'b01)
		@(negedge clk);
		chip_reset_n = 1'b0;
		repeat (4) @(negedge clk);
		chip_reset_n = 1'b1;
		repeat (4) @(negedge clk);
		`CHK(setup, FCS_SETUP_RESET)
		`CHK({filt, pt}, 2'b00)
	endtask
	task automatic summarize();
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Reset, scenarios, verdict
	initial
	begin
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge clk);
		t_reset();
		t_regs();
		t_coef();
		t_mode();
		t_abort();
		t_chip();
		summarize();
	end
	// Cut a hang short
	initial
	begin
		repeat (40000) @(posedge clk);
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
